// *** lane_err_pkg.sv ***
// Summary of operation
// - per-lane three-bit hold-enable field, lanes one, two
// - bit2 control-char, bit1 not-in-table, bit0 disparity
// - hold set: counter stops at 0xff until cleared
// - hold clear: counter wraps from 0xff to zero
// - per-lane counter-clear bits clear counters individually
package lane_err_pkg;
  localparam logic [11:0] LANE1_SAT_ADDR = 12'h489;
  localparam logic [11:0] LANE2_SAT_ADDR = 12'h48a;
  localparam logic [7:0] SAT_RESET = 8'h07;
  localparam logic [7:0] SAT_FIELD_MASK = 8'h07;
  localparam int CNT_W = 8;
  localparam logic [7:0] CNT_TERMINAL = 8'hff;
  localparam logic [7:0] CNT_ZERO = 8'h00;
  localparam int IDX_UNEXPECTED_CTRL = 2;
  localparam int IDX_NOT_IN_TABLE = 1;
  localparam int IDX_BAD_DISPARITY = 0;
  localparam int N_TYPES = 3;
endpackage : lane_err_pkg

// *** err_counter.sv ***
module err_counter #(
  parameter int W = lane_err_pkg::CNT_W
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic err,
  input wire logic hold_en,
  input wire logic clear,
  output logic [W-1:0] count
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } cnt_state_t;
  cnt_state_t s_q, s_d;
  assign count = s_q.cnt;
  always_comb begin
    s_d = s_q;
    if (clear) begin
      s_d.cnt = '0;
    end else if (err) begin
      if (hold_en && s_q.cnt == {W{1'b1}}) begin
        s_d.cnt = s_q.cnt;
      end else begin
        s_d.cnt = W'(s_q.cnt + 1'b1);
      end
    end
  end
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule : err_counter

// *** lane_error_counter_hold_ctrl.sv ***
module lane_error_counter_hold_ctrl (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [11:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic [2:0] lane1_err,
  input wire logic [2:0] lane2_err,
  input wire logic [2:0] lane1_counter_clear,
  input wire logic [2:0] lane2_counter_clear,
  output logic [7:0] lane1_ctrl_char_count,
  output logic [7:0] lane1_not_in_table_count,
  output logic [7:0] lane1_disparity_count,
  output logic [7:0] lane2_ctrl_char_count,
  output logic [7:0] lane2_not_in_table_count,
  output logic [7:0] lane2_disparity_count
);
  // hold-enable field: one bit per error type of a lane
  typedef logic [lane_err_pkg::N_TYPES-1:0] field_t;
  typedef logic [lane_err_pkg::CNT_W-1:0] count_t;

  localparam field_t FIELD_RESET = field_t'(lane_err_pkg::SAT_RESET);
  localparam logic [7:0] RDATA_RESET = '0;

  typedef struct packed {
    field_t lane1_counter_saturate_en;
    field_t lane2_counter_saturate_en;
    logic [7:0] rdata;
  } regs_t;

  regs_t r_q;
  regs_t r_d;

  // address decode and write strobes of the current cycle
  logic sel_lane1;
  logic sel_lane2;
  logic wr_lane1;
  logic wr_lane2;

  // counter values, each straight from its counter flip-flops
  count_t l1_ctrl_char_cnt;
  count_t l1_not_in_table_cnt;
  count_t l1_disparity_cnt;
  count_t l2_ctrl_char_cnt;
  count_t l2_not_in_table_cnt;
  count_t l2_disparity_cnt;

  // true when the bus address selects the given control register
  function automatic logic addr_hit(input logic [11:0] addr,
      input logic [11:0] reg_at);
    return addr == reg_at;
  endfunction : addr_hit

  // a written byte keeps only its hold-enable bits
  function automatic field_t field_of(input logic [7:0] wdata);
    logic [7:0] kept;
    kept = wdata & lane_err_pkg::SAT_FIELD_MASK;
    return field_t'(kept);
  endfunction : field_of

  // a read returns the field with the reserved bits at zero
  function automatic logic [7:0] byte_of(input field_t field);
    logic [7:0] wide;
    wide = 8'(field);
    return wide & lane_err_pkg::SAT_FIELD_MASK;
  endfunction : byte_of

  // hold bit of one error type within a lane's field
  function automatic logic hold_of(input field_t field, input int idx);
    return field[idx];
  endfunction : hold_of

  assign reg_rdata = r_q.rdata;
  assign lane1_ctrl_char_count = l1_ctrl_char_cnt;
  assign lane1_not_in_table_count = l1_not_in_table_cnt;
  assign lane1_disparity_count = l1_disparity_cnt;
  assign lane2_ctrl_char_count = l2_ctrl_char_cnt;
  assign lane2_not_in_table_count = l2_not_in_table_cnt;
  assign lane2_disparity_count = l2_disparity_cnt;

  always_comb begin
    r_d = r_q;
    sel_lane1 = addr_hit(reg_addr, lane_err_pkg::LANE1_SAT_ADDR);
    sel_lane2 = addr_hit(reg_addr, lane_err_pkg::LANE2_SAT_ADDR);
    wr_lane1 = reg_wr && sel_lane1;
    wr_lane2 = reg_wr && sel_lane2;
    // a write is taken at any time; keeping it to soft reset is up to
    // software, so a change mid-run simply retargets the next count
    if (wr_lane1) begin
      r_d.lane1_counter_saturate_en = field_of(reg_wdata);
    end
    if (wr_lane2) begin
      r_d.lane2_counter_saturate_en = field_of(reg_wdata);
    end
    // read data is registered: it shows the field as it stood in the
    // cycle the address was presented
    if (sel_lane1) begin
      r_d.rdata = byte_of(r_q.lane1_counter_saturate_en);
    end else if (sel_lane2) begin
      r_d.rdata = byte_of(r_q.lane2_counter_saturate_en);
    end else begin
      r_d.rdata = RDATA_RESET;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      r_q.lane1_counter_saturate_en <= FIELD_RESET;
      r_q.lane2_counter_saturate_en <= FIELD_RESET;
      r_q.rdata <= RDATA_RESET;
    end else begin
      r_q <= r_d;
    end
  end

  // lane 1, unexpected control character errors
  err_counter #(
    .W(lane_err_pkg::CNT_W)
  ) u_l1_ctrl_char (
    .mclk(mclk),
    .nrst(nrst),
    .err(lane1_err[lane_err_pkg::IDX_UNEXPECTED_CTRL]),
    .hold_en(hold_of(r_q.lane1_counter_saturate_en,
        lane_err_pkg::IDX_UNEXPECTED_CTRL)),
    .clear(lane1_counter_clear[lane_err_pkg::IDX_UNEXPECTED_CTRL]),
    .count(l1_ctrl_char_cnt)
  );

  // lane 1, not-in-table errors
  err_counter #(
    .W(lane_err_pkg::CNT_W)
  ) u_l1_not_in_table (
    .mclk(mclk),
    .nrst(nrst),
    .err(lane1_err[lane_err_pkg::IDX_NOT_IN_TABLE]),
    .hold_en(hold_of(r_q.lane1_counter_saturate_en,
        lane_err_pkg::IDX_NOT_IN_TABLE)),
    .clear(lane1_counter_clear[lane_err_pkg::IDX_NOT_IN_TABLE]),
    .count(l1_not_in_table_cnt)
  );

  // lane 1, bad disparity errors
  err_counter #(
    .W(lane_err_pkg::CNT_W)
  ) u_l1_disparity (
    .mclk(mclk),
    .nrst(nrst),
    .err(lane1_err[lane_err_pkg::IDX_BAD_DISPARITY]),
    .hold_en(hold_of(r_q.lane1_counter_saturate_en,
        lane_err_pkg::IDX_BAD_DISPARITY)),
    .clear(lane1_counter_clear[lane_err_pkg::IDX_BAD_DISPARITY]),
    .count(l1_disparity_cnt)
  );

  // lane 2, unexpected control character errors
  err_counter #(
    .W(lane_err_pkg::CNT_W)
  ) u_l2_ctrl_char (
    .mclk(mclk),
    .nrst(nrst),
    .err(lane2_err[lane_err_pkg::IDX_UNEXPECTED_CTRL]),
    .hold_en(hold_of(r_q.lane2_counter_saturate_en,
        lane_err_pkg::IDX_UNEXPECTED_CTRL)),
    .clear(lane2_counter_clear[lane_err_pkg::IDX_UNEXPECTED_CTRL]),
    .count(l2_ctrl_char_cnt)
  );

  // lane 2, not-in-table errors
  err_counter #(
    .W(lane_err_pkg::CNT_W)
  ) u_l2_not_in_table (
    .mclk(mclk),
    .nrst(nrst),
    .err(lane2_err[lane_err_pkg::IDX_NOT_IN_TABLE]),
    .hold_en(hold_of(r_q.lane2_counter_saturate_en,
        lane_err_pkg::IDX_NOT_IN_TABLE)),
    .clear(lane2_counter_clear[lane_err_pkg::IDX_NOT_IN_TABLE]),
    .count(l2_not_in_table_cnt)
  );

  // lane 2, bad disparity errors
  err_counter #(
    .W(lane_err_pkg::CNT_W)
  ) u_l2_disparity (
    .mclk(mclk),
    .nrst(nrst),
    .err(lane2_err[lane_err_pkg::IDX_BAD_DISPARITY]),
    .hold_en(hold_of(r_q.lane2_counter_saturate_en,
        lane_err_pkg::IDX_BAD_DISPARITY)),
    .clear(lane2_counter_clear[lane_err_pkg::IDX_BAD_DISPARITY]),
    .count(l2_disparity_cnt)
  );
endmodule : lane_error_counter_hold_ctrl

// *** lane_err_assertions.sv ***
module lane_err_chk (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic reg_wr,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic [2:0] lane1_err,
  input wire logic [2:0] lane1_counter_clear,
  input wire logic [7:0] lane1_ctrl_char_count,
  input wire logic [7:0] lane1_disparity_count
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] h_q;
  wire [7:0] u = lane1_ctrl_char_count;
  wire [7:0] b = lane1_disparity_count;
  wire [2:0] c = lane1_counter_clear;
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst) h_q <= 3'h7;
    else if (reg_wr && reg_addr == 12'h489) h_q <= reg_wdata[2:0];
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  a_rd_high: assert property (reg_rdata[7:3] == 5'h00)
    else $error("rdata high");
  a_rd_field: assert property (reg_wr && reg_addr == 12'h489 ##1
    !reg_wr && reg_addr == 12'h489 |=> reg_rdata == ($past(reg_wdata, 2)
    & 8'h07)) else $error("rdata field");
  a_cnt_inc: assert property (lane1_err[0] && !c[0] && b != 8'hff
    |=> b == $past(b) + 8'h01) else $error("count step");
  a_sel_bit: assert property (u == 8'hff && lane1_err[2] && !c[2]
    |=> u == (h_q[2] ? 8'hff : 8'h00)) else $error("select");
  a_hold_ff: assert property (h_q[2] && u == 8'hff && !c[2]
    |=> u == 8'hff) else $error("hold");
  a_wrap_zero: assert property (!h_q[0] && b == 8'hff && lane1_err[0]
    && !c[0] |=> b == 8'h00) else $error("wrap");
  a_clr_zero: assert property (c[2] |=> u == 8'h00)
    else $error("clear");
  cover property (b == 8'hff && lane1_err[0]);
  cover property (u == 8'hff && lane1_err[2]);
  cover property (c[2]);
endmodule : lane_err_chk
bind lane_error_counter_hold_ctrl lane_err_chk u_chk (
  .mclk(mclk),
  .nrst(nrst),
  .reg_wr(reg_wr),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata),
  .lane1_err(lane1_err),
  .lane1_counter_clear(lane1_counter_clear),
  .lane1_ctrl_char_count(lane1_ctrl_char_count),
  .lane1_disparity_count(lane1_disparity_count)
);

// *** lane_err_src.sv ***
module lane_err_src (
  input wire logic mclk,
  input wire logic go,
  input wire logic [2:0] kind,
  output logic [2:0] err
);
  timeunit 1ns;
  timeprecision 1ns;
  initial err = 3'h0;
  always @(negedge mclk) err <= go ? kind : 3'h0;
endmodule : lane_err_src

// *** lane_error_counter_hold_ctrl_tb.sv ***
`define CK(a, e) begin checks_done++; if ((a) !== (e)) begin n_fail++; \
  $display("CHECK FAILED %0t mismatch", $time); end end
module lane_error_counter_hold_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic reg_wr = 1'b0;
  logic go = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic [7:0] lane1_ctrl_char_count;
  logic [7:0] lane1_not_in_table_count;
  logic [7:0] lane1_disparity_count;
  logic [7:0] lane2_ctrl_char_count;
  logic [7:0] lane2_not_in_table_count;
  logic [7:0] lane2_disparity_count;
  logic [2:0] lane1_err;
  logic [2:0] lane2_err;
  logic [2:0] lane1_counter_clear = 3'h0;
  logic [2:0] lane2_counter_clear = 3'h0;
  int n_fail = 0;
  int checks_done = 0;
  initial begin
    forever #5 mclk = ~mclk;
  end
  // lane 1 sees every error type, lane 2 control-char and not-in-table
  lane_err_src p1 (.mclk(mclk), .go(go), .kind(3'h7), .err(lane1_err));
  lane_err_src p2 (.mclk(mclk), .go(go), .kind(3'h6), .err(lane2_err));
  lane_error_counter_hold_ctrl dut (
    .mclk(mclk),
    .nrst(nrst),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .lane1_err(lane1_err),
    .lane2_err(lane2_err),
    .lane1_counter_clear(lane1_counter_clear),
    .lane2_counter_clear(lane2_counter_clear),
    .lane1_ctrl_char_count(lane1_ctrl_char_count),
    .lane1_not_in_table_count(lane1_not_in_table_count),
    .lane1_disparity_count(lane1_disparity_count),
    .lane2_ctrl_char_count(lane2_ctrl_char_count),
    .lane2_not_in_table_count(lane2_not_in_table_count),
    .lane2_disparity_count(lane2_disparity_count)
  );
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge mclk) begin reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1; end
    @(negedge mclk) reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(negedge mclk) reg_addr <= a;
    repeat (2) @(negedge mclk);
    `CK(reg_rdata, e)
  endtask : rd
  task automatic burst(input int n);
    @(negedge mclk) go <= 1'b1;
    repeat (n) @(negedge mclk);
    go <= 1'b0;
    repeat (3) @(negedge mclk);
  endtask : burst
  task automatic final_report;
    $display("fails %0d checks %0d", n_fail, checks_done);
    if (n_fail == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : final_report
  initial begin
    repeat (16) @(negedge mclk);
    nrst = 1'b1;
    rd(12'h489, 8'h07);
    rd(12'h48a, 8'h07);
    rd(12'h488, 8'h00);
    wr(12'h489, 8'hfe);
    rd(12'h489, 8'h06);
    wr(12'h48a, 8'h02);
    rd(12'h48a, 8'h02);
    burst(256);
    `CK(lane1_ctrl_char_count, 8'hff)
    `CK(lane1_not_in_table_count, 8'hff)
    `CK(lane1_disparity_count, 8'h00)
    `CK(lane2_ctrl_char_count, 8'h00)
    `CK(lane2_not_in_table_count, 8'hff)
    `CK(lane2_disparity_count, 8'h00)
    @(negedge mclk) lane1_counter_clear <= 3'h4;
    @(negedge mclk) lane1_counter_clear <= 3'h0;
    @(negedge mclk);
    `CK(lane1_ctrl_char_count, 8'h00)
    `CK(lane1_not_in_table_count, 8'hff)
    burst(1);
    `CK(lane1_ctrl_char_count, 8'h01)
    `CK(lane1_not_in_table_count, 8'hff)
    `CK(lane1_disparity_count, 8'h01)
    `CK(lane2_ctrl_char_count, 8'h01)
    // one error cycle with the lane 2 not-in-table clear in the same cycle
    @(negedge mclk) go <= 1'b1;
    @(negedge mclk) begin
      go <= 1'b0;
      lane2_counter_clear <= 3'h2;
    end
    @(negedge mclk) lane2_counter_clear <= 3'h0;
    @(negedge mclk);
    `CK(lane2_not_in_table_count, 8'h00)
    `CK(lane2_ctrl_char_count, 8'h02)
    `CK(lane1_ctrl_char_count, 8'h02)
    final_report();
  end
endmodule : lane_error_counter_hold_ctrl_tb
